// File: logic/energy_to_frequency_pulse_out.sv
// top: three converters, config registers, pins, status and latch strobes
// Functional notes
// - selector fields 2:0, 5:3, 8:6 choose each converter's power type.
// - codes: total active, reactive, apparent, fund. active, fund. reactive.
// - reset: all phases included, selectors active, reactive, apparent.
// - phase powers from 8 kHz samples accumulate at a 1 MHz rate.
// - at threshold (register shifted seven bits) pulse and subtract it.
// - accumulator sign at each first-stage pulse is the sum's sign.
// - second stage divides first-stage pulses by 16-bit divider.
// - divider zero acts as one; divider one gives 1 us low.
// - period over 160 ms holds the output low for 80 ms.
// - shorter periods: 50% duty if even, (1+1/N)x50% if odd.
// - pulse pins are active low.
// - disable bits 11:9 default one and hold the pin high.
// - masked converter falls set status and drive interrupt line 0.
// - latch copies all three phase energies of selected type, then clears.
// - 8-bit cycle count sets falls between two latch events.
// - latch enable bits 14:12 default zero; work with pin disabled.
// - active mode field 1:0: 00 signed, 11 absolute, others signed.
// - absolute mode only affects pulse path, not hour registers.
// - reactive field 3:2: 10 negates when active power negative.
// - sign adjustment only affects pulse path, not hour registers.
// - phase-inclusion bits add phases A, B, C; none gives no pulses.
// - capture port enable suppresses pulse function on output 3.
// - writing one to a status bit clears it and its line.
`timescale 1ns/1ps
module energy_to_frequency_pulse_out #(
  parameter logic [22:0] LOW_HOLD_CYC    = e2f_pkg::LOW_HOLD_CYC,
  parameter logic [22:0] PERIOD_LONG_CYC = e2f_pkg::PERIOD_LONG_CYC
) (
  input  wire logic                  ref_clk,
  input  wire logic                  srst,
  // phase powers, [type][phase], held between sample strobes
  input  wire logic [4:0][2:0][23:0] power_sample,
  input  wire logic                  sample_valid,
  input  wire logic [23:0]           active_energy_threshold,
  input  wire logic [23:0]           reactive_energy_threshold,
  input  wire logic [23:0]           apparent_energy_threshold,
  input  wire logic                  capture_port_enable,
  // register writes
  input  wire logic                  cfg_we,
  input  wire logic [15:0]           cfg_wdata,
  input  wire logic                  incl_we,
  input  wire logic [8:0]            incl_wdata,
  input  wire logic [2:0]            den_we,
  input  wire logic [15:0]           den_wdata,
  input  wire logic                  cyc_we,
  input  wire logic [7:0]            cyc_wdata,
  input  wire logic                  accm_we,
  input  wire logic [7:0]            accm_wdata,
  input  wire logic                  mask_we,
  input  wire logic [31:0]           mask_wdata,
  input  wire logic                  status_we,
  input  wire logic [31:0]           status_wdata,
  // outputs
  output logic                       pulse_out_1_n,
  output logic                       pulse_out_2_n,
  output logic                       pulse_out_3_n,
  output logic                       interrupt_line_0_n,
  output logic [2:0]                 interrupt_status_0,
  output logic [15:0]                pulse_output_config,
  output logic [2:0]                 sum_sign_neg,
  output logic [2:0]                 energy_latch_strobe,
  output logic [8:0]                 energy_latch_type
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0]                         cfg;
    logic [8:0]                          incl;
    logic [2:0][15:0]                    den;
    logic [7:0]                          cyc;
    logic [7:0]                          accm;
    logic [2:0]                          mask;
    logic [2:0]                          status;
    logic                                irq_n;
    logic [2:0]                          pin_n;
    logic [2:0][e2f_pkg::SUM_W-1:0]      sum;
    logic [2:0]                          sign_neg;
    logic [2:0]                          latch_stb;
    logic [2:0][2:0]                     latch_type;
    logic [2:0][7:0]                     lcnt;
    logic [4:0]                          tick_cnt;
    logic                                tick;
  } top_state_t;

  top_state_t q;
  top_state_t d;

  logic [2:0]       conv_low;
  logic [2:0]       conv_fall;
  logic [2:0]       conv_sign;

  // ---------------------------------------------------------------
  // converters
  // ---------------------------------------------------------------
  for (genvar i = 0; i < 3; i++) begin : g_conv
    logic [23:0] conv_thr;  // one per converter, one driver each
    // threshold follows the selected power family
    always_comb begin
      unique case (q.cfg[e2f_pkg::SEL_LSB + e2f_pkg::SEL_W*i +: 3])
        e2f_pkg::SEL_TOT_REACT,
        e2f_pkg::SEL_FUND_REACT: conv_thr = reactive_energy_threshold;
        e2f_pkg::SEL_APPARENT:   conv_thr = apparent_energy_threshold;
        default:                 conv_thr = active_energy_threshold;
      endcase
    end

    e2f_converter #(
      .LOW_HOLD_CYC    (LOW_HOLD_CYC),
      .PERIOD_LONG_CYC (PERIOD_LONG_CYC)
    ) u_conv (
      .ref_clk   (ref_clk),
      .srst      (srst),
      .tick      (q.tick),
      .power     (q.sum[i]),
      .threshold (conv_thr),
      .divider   (q.den[i]),
      .conv_low  (conv_low[i]),
      .fall      (conv_fall[i]),
      .sign_neg  (conv_sign[i])
    );
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [2:0]                 sel;
    logic [2:0]                 ref_type;
    logic [e2f_pkg::PWR_W-1:0]  val;
    logic [e2f_pkg::PWR_W-1:0]  ref_pwr;
    logic [e2f_pkg::SUM_W-1:0]  acc;
    logic [1:0]                 act_mode;
    logic [1:0]                 react_mode;
    sel        = 3'h0;
    ref_type   = 3'h0;
    val        = '0;
    ref_pwr    = '0;
    acc        = '0;
    act_mode   = q.accm[e2f_pkg::ACT_MODE_LSB +: 2];
    react_mode = q.accm[e2f_pkg::REACT_MODE_LSB +: 2];
    d          = q;
    d.latch_stb = 3'h0;

    // 1 MHz tick from the 25 MHz clock
    d.tick = (q.tick_cnt == e2f_pkg::TICK_LAST);
    d.tick_cnt = d.tick ? 5'h00 : q.tick_cnt + 5'h01;

    // register writes
    if (cfg_we) begin
      d.cfg = cfg_wdata;
    end
    if (incl_we) begin
      d.incl = incl_wdata;
    end
    for (int i = 0; i < 3; i++) begin
      if (den_we[i]) begin
        d.den[i] = den_wdata;
      end
    end
    if (cyc_we) begin
      d.cyc = cyc_wdata;
    end
    if (accm_we) begin
      d.accm = accm_wdata;
    end
    if (mask_we) begin
      d.mask = mask_wdata[e2f_pkg::IRQ_LSB +: 3];
    end

    // per-converter phase sum, refreshed at each 8 kHz sample
    for (int i = 0; i < 3; i++) begin
      sel = q.cfg[e2f_pkg::SEL_LSB + e2f_pkg::SEL_W*i +: 3];
      ref_type = (sel == e2f_pkg::SEL_FUND_REACT) ?
                 e2f_pkg::SEL_FUND_ACT : e2f_pkg::SEL_TOT_ACT;
      acc = '0;
      for (int p = 0; p < 3; p++) begin
        // reserved selector codes contribute nothing
        val = (sel <= e2f_pkg::SEL_LAST) ? power_sample[sel][p] : '0;
        ref_pwr = power_sample[ref_type][p];
        // only the pulse path is altered; hour registers see raw power
        if ((sel == e2f_pkg::SEL_TOT_ACT || sel == e2f_pkg::SEL_FUND_ACT)
            && act_mode == e2f_pkg::ACT_ABSOLUTE && val[23]) begin
          val = -val;
        end
        if ((sel == e2f_pkg::SEL_TOT_REACT ||
             sel == e2f_pkg::SEL_FUND_REACT)
            && react_mode == e2f_pkg::REACT_SIGN_ADJ && ref_pwr[23]) begin
          val = -val;
        end
        if (q.incl[3*i + p]) begin
          acc = acc + {{2{val[23]}}, val};
        end
      end
      if (sample_valid) begin
        d.sum[i] = acc;
      end
    end

    // status and latch bookkeeping on each converter fall; sign and pin every cycle
    for (int i = 0; i < 3; i++) begin
      d.sign_neg[i] = conv_sign[i];
      // set wins over a clear in the same cycle
      if (status_we && status_wdata[e2f_pkg::IRQ_LSB + i]) begin
        d.status[i] = 1'b0;
      end
      if (conv_fall[i] && q.mask[i]) begin
        d.status[i] = 1'b1;
      end
      // pin: high when disabled or lent to the capture port
      if (q.cfg[e2f_pkg::DIS_LSB + i] ||
          (i == 2 && capture_port_enable)) begin
        d.pin_n[i] = 1'b1;
      end else begin
        d.pin_n[i] = ~conv_low[i];
      end
      if (!q.cfg[e2f_pkg::LATCH_LSB + i]) begin
        d.lcnt[i] = 8'h00;
      end else if (conv_fall[i]) begin
        // a zero count is taken as one fall per latch
        if (q.lcnt[i] + 8'h01 >= q.cyc || q.cyc == 8'h00) begin
          d.lcnt[i]       = 8'h00;
          d.latch_stb[i]  = 1'b1;
          d.latch_type[i] = q.cfg[e2f_pkg::SEL_LSB + e2f_pkg::SEL_W*i +: 3];
        end else begin
          d.lcnt[i] = q.lcnt[i] + 8'h01;
        end
      end
    end
    d.irq_n = ~(|d.status);
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q <= '{cfg: e2f_pkg::CFG_RST, incl: e2f_pkg::INCL_RST,
             den: {3{e2f_pkg::DEN_RST}}, cyc: e2f_pkg::CYC_RST,
             accm: e2f_pkg::ACCM_RST, mask: 3'h0, status: 3'h0,
             irq_n: 1'b1, pin_n: 3'h7, sum: '0, sign_neg: 3'h0,
             latch_stb: 3'h0, latch_type: '0, lcnt: '0,
             tick_cnt: 5'h00, tick: 1'b0};
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign pulse_out_1_n       = q.pin_n[0];
  assign pulse_out_2_n       = q.pin_n[1];
  assign pulse_out_3_n       = q.pin_n[2];
  assign interrupt_line_0_n  = q.irq_n;
  assign interrupt_status_0  = q.status;
  assign pulse_output_config = q.cfg;
  assign sum_sign_neg        = q.sign_neg;
  assign energy_latch_strobe = q.latch_stb;
  assign energy_latch_type   = q.latch_type;

endmodule

// File: logic/e2f_pkg.sv
// package: constants and field layout of the energy-to-frequency block
package e2f_pkg;

  // ---------------------------------------------------------------
  // clocking and derived cycle counts
  // ---------------------------------------------------------------
  localparam int CLK_HZ         = 25000000;
  localparam int TICK_HZ        = 1000000;
  localparam int TICK_DIV       = CLK_HZ / TICK_HZ;
  localparam int LOW_HOLD_MS    = 80;
  localparam int PERIOD_LONG_MS = 160;
  // divide first so the product stays inside 32 bits
  localparam logic [22:0] LOW_HOLD_CYC    = 23'(CLK_HZ / 1000 * LOW_HOLD_MS);
  localparam logic [22:0] PERIOD_LONG_CYC =
    23'(CLK_HZ / 1000 * PERIOD_LONG_MS);
  localparam logic [22:0] CYC_SAT         = 23'h7fffff;
  localparam logic [4:0]  TICK_LAST       = 5'(TICK_DIV - 1);

  // ---------------------------------------------------------------
  // pulse_output_config layout and reset
  // ---------------------------------------------------------------
  localparam int SEL_LSB   = 0;   // 3 bits per converter
  localparam int SEL_W     = 3;
  localparam int DIS_LSB   = 9;   // one bit per converter
  localparam int LATCH_LSB = 12;  // one bit per converter
  localparam logic [15:0] CFG_RST = 16'h0e88;

  // interrupt mask / status field position
  localparam int IRQ_LSB = 14;

  // accumulation_mode layout
  localparam int ACT_MODE_LSB   = 0;
  localparam int REACT_MODE_LSB = 2;
  localparam logic [1:0] ACT_ABSOLUTE   = 2'h3;
  localparam logic [1:0] REACT_SIGN_ADJ = 2'h2;
  localparam logic [7:0] ACCM_RST       = 8'h00;

  // other reset values
  localparam logic [8:0]  INCL_RST = 9'h1ff;
  localparam logic [15:0] DEN_RST  = 16'h0000;
  localparam logic [7:0]  CYC_RST  = 8'h01;

  // power type selector codes
  localparam logic [2:0] SEL_TOT_ACT    = 3'h0;
  localparam logic [2:0] SEL_TOT_REACT  = 3'h1;
  localparam logic [2:0] SEL_APPARENT   = 3'h2;
  localparam logic [2:0] SEL_FUND_ACT   = 3'h3;
  localparam logic [2:0] SEL_FUND_REACT = 3'h4;
  localparam logic [2:0] SEL_LAST       = 3'h4;

  localparam int PWR_W = 24;  // one phase power sample
  localparam int SUM_W = 26;  // sum of three phases
  localparam int ACC_W = 48;  // first-stage accumulator

  // output phase of one converter
  typedef enum logic {PH_HIGH, PH_LOW} out_phase_t;

endpackage

// File: logic/e2f_converter.sv
// one energy-to-frequency converter: accumulator, divider and duty shaping
`timescale 1ns/1ps
module e2f_converter #(
  parameter logic [22:0] LOW_HOLD_CYC    = e2f_pkg::LOW_HOLD_CYC,
  parameter logic [22:0] PERIOD_LONG_CYC = e2f_pkg::PERIOD_LONG_CYC
) (
  input  wire logic                      ref_clk,
  input  wire logic                      srst,
  input  wire logic                      tick,
  input  wire logic [e2f_pkg::SUM_W-1:0] power,
  input  wire logic [23:0]               threshold,
  input  wire logic [15:0]               divider,
  output logic                           conv_low,
  output logic                           fall,
  output logic                           sign_neg
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [e2f_pkg::ACC_W-1:0] acc;
    logic                      sign_neg;
    logic [15:0]               pcnt;
    e2f_pkg::out_phase_t       ph;
    logic                      fall;
    logic                      long_per;
    logic [22:0]               per_cyc;
    logic [22:0]               low_cyc;
  } conv_state_t;

  conv_state_t q;
  conv_state_t d;
  logic signed [e2f_pkg::ACC_W-1:0] sum;
  logic signed [e2f_pkg::ACC_W-1:0] thr_s;
  logic                             first;
  logic                             start;
  logic [15:0]                      den_eff;
  logic [15:0]                      half;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    d       = q;
    d.fall  = 1'b0;
    first   = 1'b0;
    start   = 1'b0;
    // zero divider counts as one
    den_eff = (divider == 16'h0000) ? 16'h0001 : divider;
    // odd divider keeps the low phase one pulse longer
    half    = 16'((17'(den_eff) + 17'h00001) >> 1);
    thr_s   = {17'h00000, threshold, 7'h00};
    sum     = q.acc + {{(e2f_pkg::ACC_W - e2f_pkg::SUM_W){power[
                e2f_pkg::SUM_W-1]}}, power};
    if (q.per_cyc != e2f_pkg::CYC_SAT) begin
      d.per_cyc = q.per_cyc + 23'h000001;
    end
    if (q.ph == e2f_pkg::PH_LOW && q.low_cyc != e2f_pkg::CYC_SAT) begin
      d.low_cyc = q.low_cyc + 23'h000001;
    end
    // the held 8 kHz sum is added on every 1 us tick; about 125
    // ticks per sample stand in for the seven-bit left shift
    if (tick) begin
      d.acc = sum;
      // zero threshold would pulse every tick, so it is ignored
      if (threshold != 24'h000000 && sum >= thr_s) begin
        d.acc      = sum - thr_s;
        first      = 1'b1;
        d.sign_neg = 1'b0;
      end else if (threshold != 24'h000000 && sum <= -thr_s) begin
        d.acc      = sum + thr_s;
        first      = 1'b1;
        d.sign_neg = 1'b1;
      end
    end
    // second stage: one output period per divider count
    if (first) begin
      if (q.pcnt + 16'h0001 >= den_eff) begin
        start      = 1'b1;
        d.pcnt     = 16'h0000;
        d.fall     = 1'b1;
        d.ph       = e2f_pkg::PH_LOW;
        d.low_cyc  = 23'h000000;
        d.per_cyc  = 23'h000000;
        d.long_per = (q.per_cyc > PERIOD_LONG_CYC);
      end else begin
        d.pcnt = q.pcnt + 16'h0001;
      end
    end
    // end of the low phase
    if (q.ph == e2f_pkg::PH_LOW && !start) begin
      if (q.long_per) begin
        if (q.low_cyc >= LOW_HOLD_CYC - 23'h000001) begin
          d.ph = e2f_pkg::PH_HIGH;
        end
      end else if (den_eff == 16'h0001) begin
        if (tick) begin
          d.ph = e2f_pkg::PH_HIGH;
        end
      end else if (first && d.pcnt >= half) begin
        d.ph = e2f_pkg::PH_HIGH;
      end
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q <= '{acc: '0, sign_neg: 1'b0, pcnt: 16'h0000,
             ph: e2f_pkg::PH_HIGH, fall: 1'b0, long_per: 1'b0,
             per_cyc: 23'h000000, low_cyc: 23'h000000};
    end else begin
      q <= d;
    end
  end

  assign conv_low = (q.ph == e2f_pkg::PH_LOW);
  assign fall     = q.fall;
  assign sign_neg = q.sign_neg;

endmodule

// File: sim/cal_equipment.sv
// partner: calibration counter watching one active-low pulse pin
`timescale 1ns/1ps
module cal_equipment (
  input  wire logic        ref_clk,
  input  wire logic        pin_n,
  output logic             done,
  output logic [15:0]      low_cyc,
  output logic [15:0]      period_cyc,
  output logic [15:0]      falls
);
  logic        prev;
  logic [15:0] lo_cnt;
  logic [15:0] per_cnt;

  initial begin
    prev = 1'b1;
    lo_cnt = 16'h0;
    per_cnt = 16'h0;
    falls = 16'h0;
    done = 1'b0;
  end

  // the lamp lights while low; one report per finished low phase
  always @(posedge ref_clk) begin
    done <= 1'b0;
    prev <= pin_n;
    lo_cnt <= pin_n ? 16'h0 : lo_cnt + 16'h1;
    per_cnt <= per_cnt + 16'h1;
    if (prev && !pin_n) begin
      falls <= falls + 16'h1;
      period_cyc <= per_cnt;
      per_cnt <= 16'h1;
    end
    if (!prev && pin_n) begin
      done <= 1'b1;
      low_cyc <= lo_cnt;
    end
  end
endmodule

// File: sim/e2f_checker_sva.sv
// checker: port-level properties of the pulse output block
`timescale 1ns/1ps
module e2f_checker #(
  parameter logic [22:0] LOW_HOLD_CYC    = e2f_pkg::LOW_HOLD_CYC,
  parameter logic [22:0] PERIOD_LONG_CYC = e2f_pkg::PERIOD_LONG_CYC
) (
  input wire logic        ref_clk,
  input wire logic        srst,
  input wire logic        capture_port_enable,
  input wire logic        cfg_we,
  input wire logic [15:0] cfg_wdata,
  input wire logic [2:0]  den_we,
  input wire logic [15:0] den_wdata,
  input wire logic        status_we,
  input wire logic [31:0] status_wdata,
  input wire logic        pulse_out_1_n,
  input wire logic        pulse_out_3_n,
  input wire logic        interrupt_line_0_n,
  input wire logic [2:0]  interrupt_status_0,
  input wire logic [15:0] pulse_output_config,
  input wire logic [2:0]  energy_latch_strobe,
  input wire logic [8:0]  energy_latch_type
);
  logic [15:0] den1_q;

  // divider of converter 1 is not read back, so shadow it here
  always_ff @(posedge ref_clk) begin
    if (srst) den1_q <= 16'h0;
    else if (den_we[0]) den1_q <= den_wdata;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  sequence s_fall1;
    $fell(pulse_out_1_n);
  endsequence
  // enabled for a while, so the fall is not an artefact of enabling
  sequence s_short_div;
    den1_q <= 16'h1 && !$past(pulse_output_config[9], 3);
  endsequence

  a_reset_idle: assert property ($fell(srst) |->
    pulse_out_1_n && interrupt_line_0_n && interrupt_status_0 == 3'h0
    && pulse_output_config == e2f_pkg::CFG_RST)
    else $error("idle state wrong after reset");
  a_pin1_disabled: assert property (
    pulse_output_config[9] && $past(pulse_output_config[9], 2)
    |-> pulse_out_1_n) else $error("disabled pin 1 went low");
  a_pin3_capture: assert property (
    capture_port_enable && $past(capture_port_enable, 2)
    |-> pulse_out_3_n) else $error("pin 3 pulsed during capture");
  a_irq_on_status: assert property (
    $rose(interrupt_status_0[0]) |-> ##[0:1] !interrupt_line_0_n)
    else $error("interrupt line not low after status set");
  a_status_w1c: assert property (
    status_we && status_wdata[14] |=> interrupt_status_0[0] == 1'b0
    ##1 interrupt_line_0_n) else $error("status not cleared by write");
  a_cfg_readback: assert property (
    cfg_we |=> pulse_output_config == $past(cfg_wdata))
    else $error("config readback differs from write");
  a_latch_type: assert property (
    energy_latch_strobe[0] |->
    energy_latch_type[2:0] == pulse_output_config[2:0])
    else $error("latch type differs from selector");
  a_latch_off: assert property (
    !pulse_output_config[12] && !$past(pulse_output_config[12], 3)
    |-> !energy_latch_strobe[0]) else $error("latch while disabled");
  a_strobe_single: assert property (
    energy_latch_strobe[0] |=> !energy_latch_strobe[0])
    else $error("latch strobe longer than one cycle");
  a_one_us_low: assert property (
    s_fall1 ##0 s_short_div |-> ##20 !pulse_out_1_n ##[1:7] pulse_out_1_n)
    else $error("low phase not one microsecond");
endmodule

bind energy_to_frequency_pulse_out e2f_checker #(
  .LOW_HOLD_CYC(LOW_HOLD_CYC),
  .PERIOD_LONG_CYC(PERIOD_LONG_CYC)
) i_e2f_checker (.ref_clk, .srst, .capture_port_enable, .cfg_we,
  .cfg_wdata, .den_we, .den_wdata, .status_we, .status_wdata,
  .pulse_out_1_n, .pulse_out_3_n, .interrupt_line_0_n,
  .interrupt_status_0, .pulse_output_config, .energy_latch_strobe,
  .energy_latch_type);

// File: sim/tb_energy_to_frequency_pulse_out.sv
// testbench: pulse timing, selectors, interrupts, signs, latching
`timescale 1ns/1ps
module tb_energy_to_frequency_pulse_out;
  localparam logic [22:0] HOLD = 23'h0000c8;
  localparam logic [22:0] LONG = 23'h000190;
  localparam logic [31:0] SKIP = 32'hffffffff;
  // sum 64 against threshold 128: a first-stage pulse every two ticks
  localparam int GAP = 2 * e2f_pkg::TICK_DIV;
  logic                  ref_clk, srst, sample_valid, capture_port_enable;
  logic [4:0][2:0][23:0] power_sample;
  logic [23:0]           th;
  logic                  cfg_we, incl_we, cyc_we, accm_we, mask_we;
  logic                  status_we;
  logic [2:0]            den_we, status, sgn, strobe;
  logic [15:0]           cfg_wdata, den_wdata, cfg_rb;
  logic [8:0]            incl_wdata, ltype;
  logic [7:0]            cyc_wdata, accm_wdata;
  logic [31:0]           mask_wdata, status_wdata, cur, c;
  logic                  p1_n, p2_n, p3_n, irq_n, m_done, pq;
  logic [15:0]           m_low, m_per, m_falls, m3_falls;
  int                    miscompares, comparisons, t, f, s;
  logic [31:0]           notes[$];
  int                    dt[6] = '{0, 1, 2, 3, 6, 9};
  int                    lt[2] = '{3, 0};

  energy_to_frequency_pulse_out #(.LOW_HOLD_CYC(HOLD),
    .PERIOD_LONG_CYC(LONG)) i_energy_to_frequency_pulse_out (.ref_clk,
    .srst, .power_sample, .sample_valid, .active_energy_threshold(th),
    .reactive_energy_threshold(th), .apparent_energy_threshold(th),
    .capture_port_enable, .cfg_we, .cfg_wdata, .incl_we, .incl_wdata,
    .den_we, .den_wdata, .cyc_we, .cyc_wdata, .accm_we, .accm_wdata,
    .mask_we, .mask_wdata, .status_we, .status_wdata,
    .pulse_out_1_n(p1_n), .pulse_out_2_n(p2_n), .pulse_out_3_n(p3_n),
    .interrupt_line_0_n(irq_n), .interrupt_status_0(status),
    .pulse_output_config(cfg_rb), .sum_sign_neg(sgn),
    .energy_latch_strobe(strobe), .energy_latch_type(ltype));
  cal_equipment i_cal_pin1 (.ref_clk, .pin_n(p1_n), .done(m_done),
    .low_cyc(m_low), .period_cyc(m_per), .falls(m_falls));
  cal_equipment i_cal_pin3 (.ref_clk, .pin_n(p3_n), .done(),
    .low_cyc(), .period_cyc(), .falls(m3_falls));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // one cycle of slack: pin edges are registered from internal events
  task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (!(got === exp || got === exp + 16'h1 || got === exp - 16'h1)) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input int r, input logic [31:0] d);
    case (r)
      0: begin cfg_we = 1'b1; cfg_wdata = d[15:0]; end
      1: begin incl_we = 1'b1; incl_wdata = d[8:0]; end
      2: begin den_we = 3'h1; den_wdata = d[15:0]; end
      3: begin cyc_we = 1'b1; cyc_wdata = d[7:0]; end
      4: begin accm_we = 1'b1; accm_wdata = d[7:0]; end
      5: begin mask_we = 1'b1; mask_wdata = d; end
      default: begin status_we = 1'b1; status_wdata = d; end
    endcase
    cyc(1);
    {cfg_we, incl_we, den_we, cyc_we, accm_we, mask_we, status_we} = '0;
  endtask
  // random split over phases a and b; neither is zero, so signs hold
  task automatic pw(input int k, input int v);
    int a;
    a = $urandom_range(63, 1);
    a = (v < 0) ? -a : a;
    power_sample[k][0] = 24'(a);
    power_sample[k][1] = 24'(v - a);
    power_sample[k][2] = 24'h0;
  endtask
  task automatic take();
    sample_valid = 1'b1;
    cyc(1);
    sample_valid = 1'b0;
  endtask
  function automatic logic [31:0] note_for(input int n);
    int ne, per, lo;
    ne = (n == 0) ? 1 : n;
    per = ne * GAP;
    lo = (per > int'(LONG)) ? int'(HOLD) :
         (ne == 1) ? GAP / 2 : (ne + 1) / 2 * GAP;
    return {16'(lo), 16'(per)};
  endfunction
  task automatic complete_run();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // oldest note is matched against each finished low phase
  always @(posedge ref_clk) begin
    if (m_done && notes.size() > 0) begin
      cur = notes.pop_front();
      if (cur !== SKIP) begin
        chk_w(m_low, cur[31:16]);
        chk_w(m_per, cur[15:0]);
      end
    end
  end

  initial begin
    repeat (60000) @(posedge ref_clk);
    miscompares++;
    complete_run();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(22565));
    {srst, sample_valid, capture_port_enable} = 3'h4;
    {cfg_we, incl_we, den_we, cyc_we, accm_we, mask_we, status_we} = '0;
    {cfg_wdata, den_wdata, incl_wdata, cyc_wdata, accm_wdata} = '0;
    {mask_wdata, status_wdata} = '0;
    power_sample = '0;
    th = 24'h1;
    cyc(12);
    srst = 1'b0;
    cyc(1);
    chk_v(cfg_rb, e2f_pkg::CFG_RST);
    chk_v({p1_n, p2_n, p3_n, irq_n, status}, 7'h78);
    pw(0, 64);
    pw(1, 64);
    pw(2, 64);
    take();
    c = m_falls;
    cyc(300);
    chk_v(m_falls, c);
    foreach (dt[i]) begin
      wr(2, dt[i]);
      wr(0, 16'h0c88);
      notes.push_back(SKIP);
      notes.push_back(SKIP);
      repeat (3) notes.push_back(note_for(dt[i]));
      t = 0;
      while (notes.size() > 0 && t < 8000) begin cyc(1); t++; end
      chk_v(notes.size(), 0);
      notes.delete();
      wr(0, 16'h0e88);
    end
    wr(2, 2);
    wr(5, 32'h4000);
    for (int k = 0; k < 10; k++) begin
      c = (k < 8) ? k : 0;
      power_sample = '0;
      take();
      wr(0, 16'h0e88 | c);
      wr(1, (k == 8) ? 9'h1f8 : (k == 9) ? 9'h1fc : 9'h1ff);
      cyc(60);
      wr(6, 32'h4000);
      pw(c % 5, 64);
      take();
      cyc(400);
      chk_v(status[0], k < 5);
      chk_v(irq_n, k >= 5);
    end
    wr(1, 9'h1ff);
    power_sample = '0;
    pw(0, -64);
    pw(1, 64);
    for (int k = 0; k < 4; k++) begin
      wr(4, {4'h0, 2'(k), 2'(k)});
      take();
      cyc(200);
      chk_v(sgn[0], k != 3);
      chk_v(sgn[1], k == 2);
    end
    wr(4, 0);
    pw(0, 64);
    pw(2, 64);
    take();
    foreach (lt[i]) begin
      wr(3, lt[i]);
      wr(0, 16'h1c88 | 2 * i);
      {f, s, t, pq} = {32'h0, 32'h0, 32'h0, p1_n};
      while (s < 3 && t < 4000) begin
        cyc(1);
        t++;
        if (pq && !p1_n) f++;
        pq = p1_n;
        if (strobe[0]) begin
          if (s == 0) f = 0;
          s++;
        end
      end
      chk_v(f, 2 * ((lt[i] == 0) ? 1 : lt[i]));
      chk_v(ltype[2:0], 2 * i);
      wr(0, 16'h0e88);
    end
    capture_port_enable = 1'b1;
    wr(0, 16'h0688);
    c = m3_falls;
    cyc(400);
    chk_v(m3_falls, c);
    capture_port_enable = 1'b0;
    cyc(400);
    chk_v(m3_falls != c, 1);
    complete_run();
  end
endmodule
